// ===== src/mbt_defines.svh
// constants of the module block-transfer engine
// assumes: included by package and design files by bare name
`ifndef MBT_DEFINES_SVH
`define MBT_DEFINES_SVH

`define MBT_WORD_W 16
`define MBT_CNT_W 9
`define MBT_MAX_WORDS 9'h100
`define MBT_UNIT_MAX 8'h03
`define MBT_SLOT_MAX 8'h0A
`define MBT_BUF_WORDS 17'h01000
`define MBT_REG_WORDS 17'h02000
`define MBT_FIFO_DEPTH 16
`define MBT_CLK_MHZ 25
`define MBT_ANSWER_NS 10000
`define MBT_ANSWER_CYC ((`MBT_ANSWER_NS * `MBT_CLK_MHZ) / 1000)

`endif

// ===== src/mbt_engine.sv
// block-transfer engine between controller registers and a module buffer
// assumes: register port and backplane port are logic on clk_in;
// the controller resolves an io word register to its module position
`include "mbt_defines.svh"
`default_nettype none

module mbt_engine
    import mbt_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    // instruction side
    input wire logic exec_in,
    input wire mbt_req_s req_in,
    output logic exec_out,
    output logic busy_out,
    output logic done_out,
    output logic instruction_fault_flag_out,
    input wire logic fault_clr_in,
    // io word register lookup (combinational, same clock)
    output logic [`MBT_WORD_W-1:0] alloc_sel_out,
    input wire logic module_io_word_register_hit_in,
    input wire logic [`MBT_WORD_W-1:0] alloc_pos_in,
    // controller register port: read data one cycle after reg_rd_out
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [`MBT_WORD_W-1:0] reg_addr_out,
    output logic [`MBT_WORD_W-1:0] reg_wdata_out,
    input wire logic [`MBT_WORD_W-1:0] reg_rdata_in,
    // backplane port: request held until ack
    output logic [`MBT_WORD_W-1:0] mod_pos_out,
    input wire logic mod_present_in,
    output logic mod_req_out,
    output logic mod_we_out,
    output logic [`MBT_WORD_W-1:0] mod_addr_out,
    output logic [`MBT_WORD_W-1:0] mod_wdata_out,
    input wire logic mod_ack_in,
    input wire logic [`MBT_WORD_W-1:0] mod_rdata_in
);
    localparam int ANS_CYC = (`MBT_ANSWER_CYC < 1) ? 1 : `MBT_ANSWER_CYC;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a table of count words from base must end inside limit
    function automatic logic table_ok(input logic [15:0] base,
                                      input logic [15:0] cnt,
                                      input logic [16:0] limit);
        logic [16:0] last;
        last = {1'b0, base} + {1'b0, cnt};
        return last <= limit;
    endfunction : table_ok

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mbt_state_e state_r, state_nxt;
    mbt_req_s req_r;
    logic exec_d_r;
    logic fault_r;
    logic [`MBT_WORD_W-1:0] pos_r;
    logic [`MBT_WORD_W-1:0] src_addr_r;
    logic [`MBT_WORD_W-1:0] dst_addr_r;
    logic [`MBT_CNT_W-1:0] src_left_r;
    logic [`MBT_CNT_W-1:0] dst_left_r;
    logic src_pend_r;
    logic [15:0] wait_cnt_r;
    logic done_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire start = exec_in && !exec_d_r && (state_r == MBT_IDLE);
    wire op_rd = req_r.op_read;
    wire const_ok = (req_r.sel[15:8] <= `MBT_UNIT_MAX) &&
                    (req_r.sel[7:0] <= `MBT_SLOT_MAX);
    wire sel_ok = req_r.sel_is_const ? const_ok
                : module_io_word_register_hit_in;
    wire [15:0] sel_pos = req_r.sel_is_const ? req_r.sel : alloc_pos_in;
    wire cnt_ok = req_r.count <= 16'(`MBT_MAX_WORDS);
    wire buf_ok = table_ok(req_r.buf_addr, req_r.count, `MBT_BUF_WORDS);
    wire regs_ok = table_ok(req_r.reg_top, req_r.count, `MBT_REG_WORDS);
    wire check_err = !sel_ok || !mod_present_in || !cnt_ok ||
                     !buf_ok || !regs_ok;

    // fifo between fetch side and store side
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`MBT_WORD_W-1:0] fifo_out_data;
    wire running = (state_r == MBT_RUN);
    wire src_issue = running && !src_pend_r && (src_left_r != '0) &&
                     fifo_in_ready;
    wire src_push = src_pend_r && (op_rd ? mod_ack_in : 1'b1);
    // module reads keep their address until the answer; register reads
    // step at once because their data returns on a fixed next cycle
    wire src_step = op_rd ? src_push : src_issue;
    wire [15:0] push_data = op_rd ? mod_rdata_in : reg_rdata_in;
    wire dst_pop = running && fifo_out_valid && (op_rd ? 1'b1 : mod_ack_in);
    wire mod_busy = running && (op_rd ? src_pend_r : fifo_out_valid);
    wire answer_lost = mod_busy && !mod_ack_in &&
                       (wait_cnt_r == 16'(ANS_CYC - 1));
    wire run_err = running && (answer_lost || !mod_present_in);
    wire run_end = running && (dst_left_r == '0);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MBT_IDLE: if (start) state_nxt = MBT_CHECK;
            MBT_CHECK: state_nxt = check_err ? MBT_FINISH : MBT_RUN;
            MBT_RUN: if (run_err || run_end) state_nxt = MBT_FINISH;
            MBT_FINISH: state_nxt = MBT_IDLE;
            default: state_nxt = MBT_IDLE;
        endcase
    end

    wire fault_set = ((state_r == MBT_CHECK) && check_err) || run_err;

    mbt_fifo #(
        .WIDTH(`MBT_WORD_W),
        .DEPTH(`MBT_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(state_r == MBT_FINISH), // drops words of an abandoned run
        .in_valid_in(src_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(push_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(op_rd ? 1'b1 : mod_ack_in),
        .out_data_out(fifo_out_data)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign exec_out = exec_d_r;
    assign busy_out = (state_r != MBT_IDLE);
    assign done_out = done_r;
    assign instruction_fault_flag_out = fault_r;
    assign alloc_sel_out = req_r.sel;
    assign mod_pos_out = pos_r;
    assign reg_rd_out = src_issue && !op_rd;
    assign reg_wr_out = running && op_rd && fifo_out_valid;
    assign reg_addr_out = op_rd ? dst_addr_r : src_addr_r;
    assign reg_wdata_out = fifo_out_data;
    assign mod_req_out = mod_busy;
    assign mod_we_out = !op_rd;
    assign mod_addr_out = op_rd ? src_addr_r : dst_addr_r;
    assign mod_wdata_out = fifo_out_data;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= MBT_IDLE;
            exec_d_r <= 1'b0;
            fault_r <= 1'b0;
            done_r <= 1'b0;
            req_r <= '0;
            pos_r <= '0;
        end else begin
            state_r <= state_nxt;
            exec_d_r <= exec_in;
            done_r <= (state_r == MBT_FINISH);
            // a new fault wins over a clear in the same cycle
            fault_r <= fault_set || (fault_r && !fault_clr_in);
            if (start) req_r <= req_in;
            if (state_r == MBT_CHECK) pos_r <= sel_pos;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_addr_r <= '0;
            dst_addr_r <= '0;
            src_left_r <= '0;
            dst_left_r <= '0;
        end else if (state_r == MBT_CHECK) begin
            src_addr_r <= op_rd ? req_r.buf_addr : req_r.reg_top;
            dst_addr_r <= op_rd ? req_r.reg_top : req_r.buf_addr;
            src_left_r <= check_err ? '0 : req_r.count[`MBT_CNT_W-1:0];
            dst_left_r <= check_err ? '0 : req_r.count[`MBT_CNT_W-1:0];
        end else if (run_err) begin
            src_left_r <= '0;
            dst_left_r <= '0;
        end else begin
            if (src_step) begin
                src_addr_r <= src_addr_r + 1'b1;
            end
            if (src_issue) begin
                src_left_r <= src_left_r - 1'b1;
            end
            if (dst_pop) begin
                dst_addr_r <= dst_addr_r + 1'b1;
                dst_left_r <= dst_left_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_pend_r <= 1'b0;
            wait_cnt_r <= '0;
        end else begin
            src_pend_r <= running && !run_err &&
                          (src_issue || (src_pend_r && !src_push));
            wait_cnt_r <= (mod_busy && !mod_ack_in && !run_err) ?
                          wait_cnt_r + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_big_count: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && req_r.count > 16'h0100) |=>
        fault_r && state_r == MBT_FINISH)
        else $error("oversize count not refused");
    a_bad_unit: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && req_r.sel_is_const &&
         req_r.sel[15:8] > 8'h03) |=> fault_r)
        else $error("unit above 3 accepted");
    a_bad_slot: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && req_r.sel_is_const &&
         req_r.sel[7:0] > 8'h0A) |=> fault_r)
        else $error("slot above 10 accepted");
    a_exec_follow: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        exec_in |=> exec_out)
        else $error("execution output not on");
    a_no_transfer: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && check_err) |=>
        (!mod_req_out && !reg_wr_out && !reg_rd_out) [*2])
        else $error("transfer after error");
    a_gone_fault: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (running && !mod_present_in) |=> fault_r && state_r == MBT_FINISH)
        else $error("disconnect not flagged");
    a_range_fault: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && !regs_ok) |=> fault_r)
        else $error("register range not checked");
    a_src_step: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (src_step && !run_err) |=> src_addr_r == $past(src_addr_r) + 16'h0001)
        else $error("source address not ascending");
    a_rd_write: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        reg_wr_out |=> dst_addr_r == $past(reg_addr_out) + 16'h0001 ||
                       state_r == MBT_FINISH)
        else $error("register write address not stepping");
    a_rd_data: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_out && !run_err) |=> src_push)
        else $error("register word not captured");
    a_start_cap: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        start |=> req_r.count == $past(req_in.count) && state_r == MBT_CHECK)
        else $error("parameter pair not taken");
    a_sel_fault: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r == MBT_CHECK && !req_r.sel_is_const &&
         !module_io_word_register_hit_in) |=> fault_r)
        else $error("bad register selector accepted");
    a_req_hold: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (mod_req_out && !mod_ack_in && !run_err) |=> $stable(mod_addr_out))
        else $error("module address moved before answer");
endmodule : mbt_engine

`default_nettype wire

// ===== src/mbt_fifo.sv
// synchronous FIFO with valid/ready on both sides and a flush
// assumes: single clock, reader may stall so the FIFO really fills
`default_nettype none

module mbt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] fill_r;

    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (fill_r != (AW+1)'(DEPTH));
    assign out_valid_out = (fill_r != '0);
    assign out_data_out = mem_r[rd_ptr_r];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
        end else if (flush_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fill_r <= (AW+1)'(DEPTH))
        else $error("fifo fill beyond depth");
endmodule : mbt_fifo

`default_nettype wire

// ===== src/mbt_pkg.sv
// types of the module block-transfer engine
// assumes: mbt_defines.svh on the include path
`include "mbt_defines.svh"
`default_nettype none

package mbt_pkg;
    typedef logic [`MBT_WORD_W-1:0] mbt_word_t;

    // gray sequence idle -> check -> run -> finish
    typedef enum logic [1:0] {
        MBT_IDLE = 2'h0,
        MBT_CHECK = 2'h1,
        MBT_RUN = 2'h3,
        MBT_FINISH = 2'h2
    } mbt_state_e;

    typedef struct packed {
        logic op_read;      // 1: module -> registers, 0: registers -> module
        logic sel_is_const; // selector is a unit/slot position constant
        mbt_word_t sel;
        mbt_word_t buf_addr;
        mbt_word_t count;
        mbt_word_t reg_top;
    } mbt_req_s;
endpackage : mbt_pkg

`default_nettype wire

// ===== verification/mbt_module_model.sv
// behavioural buffer memory of the special module on the backplane
// assumes: engine holds request until ack, one request outstanding
`default_nettype none

module mbt_module_model (
    input wire logic clk_in,
    input wire logic mute_in,
    input wire logic [3:0] delay_in,
    input wire logic mod_req_in,
    input wire logic mod_we_in,
    input wire logic [15:0] mod_addr_in,
    input wire logic [15:0] mod_wdata_in,
    output logic mod_ack_out,
    output logic [15:0] mod_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // answer logic
    // ------------------------------------------------------------
    logic [15:0] mem [0:4095];
    logic [3:0] wait_r;
    initial begin
        mod_ack_out = 1'b0;
        mod_rdata_out = 16'h0000;
        wait_r = 4'h0;
    end
    // data line toggles outside ack so a stale value never looks valid
    always @(posedge clk_in) begin
        if (mod_ack_out) begin
            mod_ack_out <= 1'b0;
            wait_r <= 4'h0;
            mod_rdata_out <= ~mod_rdata_out;
        end else if (mod_req_in && !mute_in && wait_r == delay_in) begin
            mod_ack_out <= 1'b1;
            if (mod_we_in) begin
                mem[mod_addr_in[11:0]] <= mod_wdata_in;
            end else begin
                mod_rdata_out <= mem[mod_addr_in[11:0]];
            end
        end else begin
            mod_rdata_out <= ~mod_rdata_out;
            if (mod_req_in && !mute_in) begin
                wait_r <= wait_r + 4'h1;
            end else begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule : mbt_module_model

`default_nettype wire

// ===== verification/test_mbt_engine.sv
// self-checking bench of the block-transfer engine
// assumes: mbt_pkg compiled first, register space and lookup modelled here
`default_nettype none

module test_mbt_engine;
    import mbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // stimulus, register model and instances
    // ------------------------------------------------------------
    logic clk_in, rst_n_in, exec_in, fault_clr_in, mod_present_in;
    logic mute, exec_out, busy_out, done_out, instruction_fault_flag_out;
    logic reg_rd_out, reg_wr_out, mod_req_out, mod_we_out, mod_ack_in;
    logic [3:0] delay;
    mbt_req_s req_in;
    logic [15:0] alloc_sel_out, reg_addr_out, reg_wdata_out, reg_rdata_in;
    logic [15:0] mod_pos_out, mod_addr_out, mod_wdata_out, mod_rdata_in;
    logic [15:0] regs [0:8191];
    wire logic io_hit;
    wire logic [15:0] io_pos;
    int n_errors = 0;
    int checks = 0;

    // io word register 16'h0014 stands for unit 1 slot 2
    assign io_hit = (alloc_sel_out == 16'h0014);
    assign io_pos = 16'h0102;

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (reg_wr_out) begin
            regs[reg_addr_out[12:0]] <= reg_wdata_out;
        end
        reg_rdata_in <= reg_rd_out ? regs[reg_addr_out[12:0]] : ~reg_rdata_in;
    end

    mbt_engine dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .exec_in(exec_in),
        .req_in(req_in), .exec_out(exec_out), .busy_out(busy_out),
        .done_out(done_out), .fault_clr_in(fault_clr_in),
        .instruction_fault_flag_out(instruction_fault_flag_out),
        .alloc_sel_out(alloc_sel_out),
        .module_io_word_register_hit_in(io_hit), .alloc_pos_in(io_pos),
        .reg_rd_out(reg_rd_out), .reg_wr_out(reg_wr_out),
        .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out),
        .reg_rdata_in(reg_rdata_in), .mod_pos_out(mod_pos_out),
        .mod_present_in(mod_present_in), .mod_req_out(mod_req_out),
        .mod_we_out(mod_we_out), .mod_addr_out(mod_addr_out),
        .mod_wdata_out(mod_wdata_out), .mod_ack_in(mod_ack_in),
        .mod_rdata_in(mod_rdata_in));

    mbt_module_model u_mod (.clk_in(clk_in), .mute_in(mute),
        .delay_in(delay), .mod_req_in(mod_req_out), .mod_we_in(mod_we_out),
        .mod_addr_in(mod_addr_out), .mod_wdata_in(mod_wdata_out),
        .mod_ack_out(mod_ack_in), .mod_rdata_out(mod_rdata_in));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // one instruction: hold exec high until done, then clear the flag
    task automatic run(input logic rd, input logic k, input logic [15:0] s,
                       input logic [15:0] b, input logic [15:0] n,
                       input logic [15:0] t, input logic ef);
        int i;
        @(negedge clk_in);
        req_in = '{rd, k, s, b, n, t};
        exec_in = 1'b1;
        i = 0;
        do begin
            @(negedge clk_in);
            i++;
            if (i == 1) chk(busy_out, 1'b1);
        end while (done_out !== 1'b1 && i < 3000);
        if (i >= 3000) begin
            n_errors++;
            summarize();
        end
        chk(exec_out, 1'b1);
        chk(busy_out, 1'b0);
        chk(instruction_fault_flag_out, ef);
        exec_in = 1'b0;
        fault_clr_in = 1'b1;
        @(negedge clk_in);
        fault_clr_in = 1'b0;
        chk(instruction_fault_flag_out, 1'b0);
        repeat (2) @(negedge clk_in);
    endtask : run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read();
        for (int i = 0; i < 21; i++) begin
            u_mod.mem[16'h0010 + i] = 16'hA100 + 16'(i);
            regs[16'h0100 + i] = 16'h0000;
        end
        run(1'b1, 1'b1, 16'h0004, 16'h0010, 16'h0014, 16'h0100, 1'b0);
        for (int i = 0; i < 20; i++) begin
            chk(regs[16'h0100 + i], 16'hA100 + 16'(i));
        end
        chk(regs[16'h0114], 16'h0000);
        chk(mod_pos_out, 16'h0004);
        $display("read test done");
    endtask : t_read

    task automatic t_write();
        delay = 4'h6;
        for (int i = 0; i < 20; i++) begin
            regs[16'h0200 + i] = 16'hB200 + 16'(i);
        end
        run(1'b0, 1'b0, 16'h0014, 16'h0400, 16'h0014, 16'h0200, 1'b0);
        for (int i = 0; i < 20; i++) begin
            chk(u_mod.mem[16'h0400 + i], 16'hB200 + 16'(i));
        end
        chk(mod_pos_out, 16'h0102);
        delay = 4'h0;
        $display("write test done");
    endtask : t_write

    task automatic t_limit();
        u_mod.mem[16'h02FF] = 16'h5A5A;
        run(1'b1, 1'b1, 16'h0004, 16'h0200, 16'h0100, 16'h0300, 1'b0);
        chk(regs[16'h03FF], 16'h5A5A);
        run(1'b1, 1'b1, 16'h0004, 16'h0000, 16'h0000, 16'h0300, 1'b0);
        regs[16'h0500] = 16'h1234;
        run(1'b1, 1'b1, 16'h0004, 16'h0000, 16'h0101, 16'h0500, 1'b1);
        chk(regs[16'h0500], 16'h1234);
        $display("limit test done");
    endtask : t_limit

    task automatic t_select();
        run(1'b1, 1'b1, 16'h030A, 16'h0000, 16'h0001, 16'h0600, 1'b0);
        run(1'b1, 1'b0, 16'h0014, 16'h0000, 16'h0001, 16'h0600, 1'b0);
        chk(mod_pos_out, 16'h0102);
        run(1'b1, 1'b1, 16'h0400, 16'h0000, 16'h0001, 16'h0600, 1'b1);
        run(1'b1, 1'b1, 16'h000B, 16'h0000, 16'h0001, 16'h0600, 1'b1);
        run(1'b0, 1'b0, 16'h0099, 16'h0000, 16'h0001, 16'h0600, 1'b1);
        $display("selector test done");
    endtask : t_select

    task automatic t_absent();
        mod_present_in = 1'b0;
        run(1'b1, 1'b1, 16'h0004, 16'h0000, 16'h0002, 16'h0600, 1'b1);
        mod_present_in = 1'b1;
        mute = 1'b1;
        run(1'b0, 1'b1, 16'h0004, 16'h0000, 16'h0002, 16'h0600, 1'b1);
        mute = 1'b0;
        // pull the module out while a slow read is still waiting for its answer
        delay = 4'hF;
        regs[16'h0610] = 16'h3C3C;
        fork
            run(1'b1, 1'b1, 16'h0004, 16'h0000, 16'h0002, 16'h0610,
                1'b1);
            begin
                repeat (5) @(negedge clk_in);
                mod_present_in = 1'b0;
            end
        join
        mod_present_in = 1'b1;
        delay = 4'h0;
        chk(regs[16'h0610], 16'h3C3C);
        $display("answer test done");
    endtask : t_absent

    task automatic t_range();
        u_mod.mem[16'h0FFF] = 16'h7777;
        run(1'b0, 1'b1, 16'h0004, 16'h0FFF, 16'h0002, 16'h0600, 1'b1);
        chk(u_mod.mem[16'h0FFF], 16'h7777);
        regs[16'h1FFF] = 16'h4321;
        run(1'b1, 1'b1, 16'h0004, 16'h0000, 16'h0002, 16'h1FFF, 1'b1);
        chk(regs[16'h1FFF], 16'h4321);
        $display("range test done");
    endtask : t_range

    initial begin
        exec_in = 1'b0;
        req_in = '0;
        fault_clr_in = 1'b0;
        mod_present_in = 1'b1;
        mute = 1'b0;
        delay = 4'h0;
        reg_rdata_in = 16'h0000;
        rst_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_read();
        t_write();
        t_limit();
        t_select();
        t_absent();
        t_range();
        summarize();
    end
endmodule : test_mbt_engine

`default_nettype wire
